//--- hdl/tws_slave_top.sv
// two-wire slave word access: bus engine on the link clock, register side on core_clk
`timescale 1ns/1ps
`include "tws_defines.svh"
module tws_slave_top #(
  parameter int TIMEOUT_CYCLES = `TWS_TIMEOUT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        linkClk,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [1:0]  addrStrapHigh,
  input  wire logic [1:0]  addrStrapLow,
  output logic      [7:0]  regPtr,
  output logic             regWrStrobe,
  output logic      [15:0] regWrData,
  input  wire logic [15:0] regRdData,
  output logic             highSpeedMode,
  output logic             busTimeout
);
  import tws_pkg::*;

  // timeout terminal count, fixed at the counter width
  localparam logic [21:0] TMO_LAST = 22'(TIMEOUT_CYCLES - 1);

  // state of the bus engine, link clock domain
  typedef struct packed {
    tws_state_type state;    // protocol phase
    logic [3:0]    bitCnt;   // bits of the current byte seen
    logic [7:0]    shReg;    // receive or transmit shifter
    logic          ackPhase; // inside the ninth clock
    logic          sdaDrive; // pulling the data line low
    logic [1:0]    byteIdx;  // bytes done since the address
    logic          mNack;    // master answered not-acknowledge
    logic          hsMode;   // high-speed filtering selected
    logic [6:0]    myAddr;   // address taken at the last start
    logic [7:0]    ptr;      // register pointer
    logic [7:0]    msb;      // upper byte waiting for its partner
    logic [15:0]   rdWord;   // latest word of the pointed register
    logic [15:0]   txWord;   // word frozen for the running read
    logic          evtValid; // one-cycle event launch
    tws_event_type evt;      // event payload
    logic          busy;     // transaction in progress, clock low
    logic          abortS1;  // timeout abort, first stage
    logic          abortS2;  // timeout abort, second stage
    logic          sclD;     // clock level one cycle ago
    logic          sdaD;     // data level one cycle ago
  } tws_link_type;

  // state of the register side, core clock domain
  typedef struct packed {
    logic [7:0]  ptr;      // pointer mirror
    logic        wrStrobe; // one-cycle write pulse
    logic [15:0] wrData;   // word to store
    logic        busyS1;   // engine busy, first stage
    logic        busyS2;   // engine busy, second stage
    logic        hsS1;     // high-speed flag, first stage
    logic        hsS2;     // high-speed flag, second stage
    logic [21:0] tmoCnt;   // cycles of one clock-low stall
    logic        abort;    // timeout reached, held until busy drops (clock high or bus idle)
    logic        tmoPulse; // one-cycle timeout report
  } tws_core_type;

  tws_link_type  lk_r;       // link registers
  tws_link_type  lk_nxt;     // link next state
  tws_core_type  co_r;       // core registers
  tws_core_type  co_nxt;     // core next state
  logic          rstLinkS1;  // reset into the link domain, first stage
  logic          rstLinkS2;  // reset as seen by the link domain
  logic [5:0]    pinLvl;     // filtered pin levels
  logic          sclLvl;     // filtered clock line
  logic          sdaLvl;     // filtered data line
  logic [1:0]    strapHigh;  // filtered high strap code
  logic [1:0]    strapLow;   // filtered low strap code
  logic          sclRise;    // clock line rose
  logic          sclFall;    // clock line fell
  logic          startSeen;  // data fell with the clock high
  logic          stopSeen;   // data rose with the clock high
  tws_event_type evtCore;    // event arrived on the core side
  logic          evtValid;   // event arrival pulse
  logic          rdValid;    // fresh read word arrived on the link side
  logic [15:0]   rdWordLink; // read word on the link side
  logic [7:0]    txByte;     // next byte of a read

  // reset crosses into the link domain through two stages
  always_ff @(posedge linkClk) begin
    rstLinkS1 <= rst;
    rstLinkS2 <= rstLinkS1;
  end

  // pins and straps through three stages and the spike filter
  tws_pin_sync #(
    .W (6)
  ) u_pins (
    .clk    (linkClk),
    .rst    (rstLinkS2),
    .hsMode (lk_r.hsMode),
    .pinIn  ({addrStrapHigh, addrStrapLow, sdaIn, sclIn}),
    .level  (pinLvl)
  );

  assign sclLvl = pinLvl[0];
  assign sdaLvl = pinLvl[1];
  assign strapLow = pinLvl[3:2];
  assign strapHigh = pinLvl[5:4];

  // bus conditions from the filtered levels
  assign sclRise = sclLvl & ~lk_r.sclD;
  assign sclFall = ~sclLvl & lk_r.sclD;
  assign startSeen = sclLvl & lk_r.sclD & lk_r.sdaD & ~sdaLvl;
  assign stopSeen = sclLvl & lk_r.sclD & ~lk_r.sdaD & sdaLvl;

  // next byte of a read: upper half first, then lower
  // upper byte first
  assign txByte = lk_r.byteIdx[0] ? lk_r.txWord[7:0] : lk_r.txWord[15:8];

  // bus engine: bits shift on clock rises, the data line changes on falls
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.evtValid = 1'b0;
    lk_nxt.sclD = sclLvl;
    lk_nxt.sdaD = sdaLvl;
    lk_nxt.abortS1 = co_r.abort;
    lk_nxt.abortS2 = lk_r.abortS1;
    // keep the newest copy of the pointed register
    if (rdValid) begin
      lk_nxt.rdWord = rdWordLink;
    end
    if (lk_r.abortS2) begin
      lk_nxt.state = ST_IDLE;
      lk_nxt.sdaDrive = 1'b0;
      lk_nxt.ackPhase = 1'b0;
    end else if (stopSeen) begin
      lk_nxt.state = ST_IDLE;
      lk_nxt.sdaDrive = 1'b0;
      lk_nxt.ackPhase = 1'b0;
      lk_nxt.hsMode = 1'b0;
    end else if (startSeen) begin
      lk_nxt.state = ST_ADDR;
      lk_nxt.bitCnt = 4'h0;
      lk_nxt.ackPhase = 1'b0;
      lk_nxt.sdaDrive = 1'b0;
      lk_nxt.byteIdx = 2'h0;
      lk_nxt.mNack = 1'b0;
      lk_nxt.myAddr = {`TWS_ADDR_FIXED, strapHigh, strapLow};
    end else if (lk_r.state != ST_IDLE && lk_r.state != ST_SKIP) begin
      if (sclRise) begin
        if (!lk_r.ackPhase) begin
          lk_nxt.shReg = {lk_r.shReg[6:0], sdaLvl};
          lk_nxt.bitCnt = lk_r.bitCnt + 4'h1;
        end else begin
          // ninth bit: master acknowledge of a read byte
          lk_nxt.mNack = sdaLvl;
        end
      end else if (sclFall) begin
        if (!lk_r.ackPhase && lk_r.bitCnt == `TWS_BYTE_BITS) begin
          // a byte is complete: decide the acknowledge
          lk_nxt.ackPhase = 1'b1;
          lk_nxt.sdaDrive = 1'b0;
          unique case (lk_r.state)
            ST_ADDR: begin
              if (lk_r.shReg[7:3] == `TWS_MCODE_TOP) begin
                lk_nxt.hsMode = 1'b1;
                lk_nxt.state = ST_SKIP;
              end else if (lk_r.shReg[7:1] == lk_r.myAddr) begin
                lk_nxt.sdaDrive = 1'b1;
                lk_nxt.state = lk_r.shReg[0] ? ST_READ : ST_WRITE;
                // read data frozen here so both halves match
                lk_nxt.txWord = lk_r.rdWord;
                lk_nxt.mNack = 1'b0;
              end else begin
                // another slave is addressed
                lk_nxt.state = ST_SKIP;
              end
            end
            ST_WRITE: begin
              lk_nxt.sdaDrive = 1'b1;
              if (lk_r.byteIdx == 2'h0) begin
                lk_nxt.ptr = lk_r.shReg;
                lk_nxt.evt = '{isData: 1'b0, ptr: lk_r.shReg, data: 16'h0000};
                lk_nxt.evtValid = 1'b1;
              end else if (lk_r.byteIdx == 2'h1) begin
                // upper byte waits for the lower one
                lk_nxt.msb = lk_r.shReg;
              end else if (lk_r.byteIdx == `TWS_WR_LAST) begin
                lk_nxt.evt = '{isData: 1'b1, ptr: lk_r.ptr, data: {lk_r.msb, lk_r.shReg}};
                lk_nxt.evtValid = 1'b1;
              end
              if (lk_r.byteIdx != `TWS_WR_DROP) begin
                lk_nxt.byteIdx = lk_r.byteIdx + 2'h1;
              end
            end
            ST_READ, ST_IDLE, ST_SKIP: begin
              // release the line so the master can answer
              lk_nxt.sdaDrive = 1'b0;
            end
          endcase
        end else if (lk_r.ackPhase) begin
          // end of the ninth clock: next byte begins
          lk_nxt.ackPhase = 1'b0;
          lk_nxt.bitCnt = 4'h0;
          lk_nxt.sdaDrive = 1'b0;
          if (lk_r.state == ST_READ) begin
            if (lk_r.mNack) begin
              lk_nxt.state = ST_SKIP;
            end else begin
              lk_nxt.shReg = txByte;
              lk_nxt.sdaDrive = ~txByte[7];
              lk_nxt.byteIdx = lk_r.byteIdx + 2'h1;
            end
          end
        end else if (lk_r.state == ST_READ) begin
          // present the next bit while the clock is low
          lk_nxt.sdaDrive = ~lk_r.shReg[7];
        end
      end
    end
    // busy with the clock held low, registered so the core side sees a clean level;
    // timing only clock-low spans lets slow but legal masters finish long transfers
    lk_nxt.busy = (lk_nxt.state != ST_IDLE) && !sclLvl;
  end

  // link domain registers
  always_ff @(posedge linkClk) begin
    if (rstLinkS2) begin
      lk_r <= '0;
      lk_r.state <= ST_IDLE;
      lk_r.sclD <= 1'b1;
      lk_r.sdaD <= 1'b1;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // pointer and write events cross to the core side
  // a new event comes at most once per byte, far slower than the handshake
  tws_toggle_xfer #(
    .W ($bits(tws_event_type))
  ) u_evt_xfer (
    .srcClk   (linkClk),
    .srcRst   (rstLinkS2),
    .srcValid (lk_r.evtValid),
    .srcData  (lk_r.evt),
    .srcReady (),
    .dstClk   (core_clk),
    .dstRst   (rst),
    .dstValid (evtValid),
    .dstData  (evtCore)
  );

  // the pointed register is sent over again and again, so the
  // link side always holds a copy at most a few cycles old
  tws_toggle_xfer #(
    .W (16)
  ) u_rd_xfer (
    .srcClk   (core_clk),
    .srcRst   (rst),
    .srcValid (1'b1),
    .srcData  (regRdData),
    .srcReady (),
    .dstClk   (linkClk),
    .dstRst   (rstLinkS2),
    .dstValid (rdValid),
    .dstData  (rdWordLink)
  );

  // register side: pointer mirror, write pulse and timeout
  always_comb begin
    co_nxt = co_r;
    co_nxt.wrStrobe = 1'b0;
    co_nxt.tmoPulse = 1'b0;
    co_nxt.busyS1 = lk_r.busy;
    co_nxt.busyS2 = co_r.busyS1;
    co_nxt.hsS1 = lk_r.hsMode;
    co_nxt.hsS2 = co_r.hsS1;
    if (evtValid) begin
      co_nxt.ptr = evtCore.ptr;
      if (evtCore.isData) begin
        co_nxt.wrStrobe = 1'b1;
        co_nxt.wrData = evtCore.data;
      end
    end
    if (!co_r.busyS2) begin
      // clock high or bus idle: stall count restarts
      co_nxt.tmoCnt = 22'h00_0000;
      co_nxt.abort = 1'b0;
    end else if (!co_r.abort) begin
      if (co_r.tmoCnt == TMO_LAST) begin
        co_nxt.abort = 1'b1;
        co_nxt.tmoPulse = 1'b1;
      end else begin
        co_nxt.tmoCnt = co_r.tmoCnt + 22'h00_0001;
      end
    end
  end

  // core domain registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      co_r <= '0;
    end else begin
      co_r <= co_nxt;
    end
  end

  // the data line is only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOe = lk_r.sdaDrive;
  assign sclOut = 1'b0;
  assign sclOe = 1'b0;

  // register side outputs
  assign regPtr = co_r.ptr;
  assign regWrStrobe = co_r.wrStrobe;
  assign regWrData = co_r.wrData;
  assign highSpeedMode = co_r.hsS2;
  assign busTimeout = co_r.tmoPulse;
endmodule : tws_slave_top

//--- hdl/tws_defines.svh
// shared constants of the two-wire slave word access block
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
// fixed upper bits of the slave address
`define TWS_ADDR_FIXED    3'h4
// top five bits of the high-speed master code
`define TWS_MCODE_TOP     5'h01
// link clock period in ns
`define TWS_LINK_NS       32
// least spike width suppressed in fast mode, in ns
`define TWS_SPIKE_FS_NS   50
// least spike width suppressed in high-speed mode, in ns
`define TWS_SPIKE_HS_NS   10
// filter lengths in link cycles, rounded up
`define TWS_FILT_FS       ((`TWS_SPIKE_FS_NS + `TWS_LINK_NS - 1) / `TWS_LINK_NS)
`define TWS_FILT_HS       ((`TWS_SPIKE_HS_NS + `TWS_LINK_NS - 1) / `TWS_LINK_NS)
// stalled-transaction timeout in ms
`define TWS_TIMEOUT_MS    28
// core clock rate in kHz
`define TWS_CORE_KHZ      100000
// timeout in core cycles
`define TWS_TIMEOUT_CYC   (`TWS_TIMEOUT_MS * `TWS_CORE_KHZ)
// bit count of one byte on the wire
`define TWS_BYTE_BITS     4'h8
// write byte index of the last stored byte
`define TWS_WR_LAST       2'h2
// write byte index at which counting stops and data is dropped
`define TWS_WR_DROP       2'h3
`endif

//--- hdl/tws_pkg.sv
// types of the two-wire slave word access block
package tws_pkg;
  // bus engine states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_SKIP} tws_state_type;
  // event carried from the bus engine to the register side
  typedef struct packed {
    logic        isData;
    logic [7:0]  ptr;
    logic [15:0] data;
  } tws_event_type;
endpackage : tws_pkg

//--- hdl/tws_pin_sync.sv
// pin synchroniser with agreement check and mode-dependent spike filter
`timescale 1ns/1ps
`include "tws_defines.svh"
module tws_pin_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         hsMode,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level
);
  import tws_pkg::*;

  // three-stage chains, filtered level and spike counters
  typedef struct packed {
    logic [W-1:0]      s1;
    logic [W-1:0]      s2;
    logic [W-1:0]      s3;
    logic [W-1:0]      lvl;
    logic [W-1:0][1:0] cnt;
  } tws_sync_type;

  tws_sync_type st_r;   // registered state
  tws_sync_type st_nxt; // next state
  logic [1:0]   limit;  // cycles a new level must persist

  // s1 feeds s2 only; filtering looks at s2 and s3
  always_comb begin
    limit = hsMode ? 2'(`TWS_FILT_HS) : 2'(`TWS_FILT_FS);
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] != st_r.s3[i] || st_r.s3[i] == st_r.lvl[i]) begin
        st_nxt.cnt[i] = 2'h0;
      end else if (st_r.cnt[i] >= limit) begin
        st_nxt.lvl[i] = st_r.s3[i];
        st_nxt.cnt[i] = 2'h0;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + 2'h1;
      end
    end
  end

  // idle bus reads high, so everything resets high
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.lvl;
endmodule : tws_pin_sync

//--- hdl/tws_toggle_xfer.sv
// toggle handshake carrying one word between two clock domains
`timescale 1ns/1ps
module tws_toggle_xfer #(
  parameter int W = 16
) (
  input  wire logic         srcClk,
  input  wire logic         srcRst,
  input  wire logic         srcValid,
  input  wire logic [W-1:0] srcData,
  output logic              srcReady,
  input  wire logic         dstClk,
  input  wire logic         dstRst,
  output logic              dstValid,
  output logic      [W-1:0] dstData
);
  import tws_pkg::*;

  // source side: held word, request toggle, synced acknowledge
  typedef struct packed {
    logic [W-1:0] hold;
    logic         tog;
    logic         ackS1;
    logic         ackS2;
  } tws_xsrc_type;

  // destination side: synced request, own toggle, word, pulse
  typedef struct packed {
    logic         reqS1;
    logic         reqS2;
    logic         tog;
    logic [W-1:0] data;
    logic         valid;
  } tws_xdst_type;

  tws_xsrc_type sr_r;   // source registers
  tws_xsrc_type sr_nxt; // source next
  tws_xdst_type ds_r;   // destination registers
  tws_xdst_type ds_nxt; // destination next

  // the held word stays still until the far side has copied it
  assign srcReady = (sr_r.tog == sr_r.ackS2);

  // source: launch a word when the previous one is acknowledged
  always_comb begin
    sr_nxt = sr_r;
    sr_nxt.ackS1 = ds_r.tog;
    sr_nxt.ackS2 = sr_r.ackS1;
    if (srcValid && srcReady) begin
      sr_nxt.hold = srcData;
      sr_nxt.tog = ~sr_r.tog;
    end
  end

  // destination: copy the word once the toggle has crossed
  always_comb begin
    ds_nxt = ds_r;
    ds_nxt.valid = 1'b0;
    ds_nxt.reqS1 = sr_r.tog;
    ds_nxt.reqS2 = ds_r.reqS1;
    if (ds_r.reqS2 != ds_r.tog) begin
      ds_nxt.tog = ds_r.reqS2;
      ds_nxt.data = sr_r.hold;
      ds_nxt.valid = 1'b1;
    end
  end

  // source domain registers
  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      sr_r <= '0;
    end else begin
      sr_r <= sr_nxt;
    end
  end

  // destination domain registers
  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      ds_r <= '0;
    end else begin
      ds_r <= ds_nxt;
    end
  end

  assign dstValid = ds_r.valid;
  assign dstData = ds_r.data;
endmodule : tws_toggle_xfer

//--- test/tws_bus_master.sv
// behavioural two-wire bus master for the slave bench
`timescale 1ns/1ps
module tws_bus_master (
  output logic      scl,
  output logic      sda,
  input  wire logic sdaW
);
  int qt = 625;
  // both lines start released, pull-ups give high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start();
    #qt sda = 1'b1;
    #qt scl = 1'b1;
    #qt sda = 1'b0;
    #qt scl = 1'b0;
  endtask : start
  // stop, then idle with clock still
  task automatic stop();
    #qt sda = 1'b0;
    #qt scl = 1'b1;
    #qt sda = 1'b1;
    #(2 * qt);
  endtask : stop
  // eight bits msb first, then acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] rd, output logic ackOut);
    logic [8:0] o;
    logic [8:0] r;
    o = {d, ackIn};
    for (int i = 8; i >= 0; i--) begin
      // data changes a quarter after the fall, keeping hold time
      #qt sda = o[i];
      #qt scl = 1'b1;
      #qt r[i] = sdaW;
      #qt scl = 1'b0;
    end
    rd = r[8:1];
    ackOut = r[0];
  endtask : xfer
endmodule : tws_bus_master

//--- test/tws_slave_assertions.sv
// port assertions of the two-wire slave
`timescale 1ns/1ps
module tws_slave_assertions #(
  parameter int TIMEOUT_CYCLES = 2000
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic        sclOut,
  input wire logic        sclOe,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic [7:0]  regPtr,
  input wire logic        regWrStrobe,
  input wire logic [15:0] regWrData,
  input wire logic        highSpeedMode,
  input wire logic        busTimeout
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // slave only: clock line never pulled
  clk_not_driven_a: assert property (!sclOe && !sclOut)
    else $error("clock line driven");
  data_low_only_a: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  // new drive starts only while the clock is low
  drive_in_low_a: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data drive began with clock high");
  // a word needs two bytes, so strobes are far apart
  strobe_spacing_a: assert property (regWrStrobe |=> !regWrStrobe [*8])
    else $error("write strobes too close");
  ptr_steady_wr_a: assert property (regWrStrobe |-> $stable(regPtr))
    else $error("pointer moved with a word store");
  word_held_a: assert property (!regWrStrobe |-> $stable(regWrData))
    else $error("write word changed without strobe");
  timeout_pulse_a: assert property (busTimeout |=> !busTimeout)
    else $error("timeout longer than one cycle");
  timeout_release_a: assert property (busTimeout |-> ##[1:40] !sdaOe)
    else $error("data line held after timeout");
  // master code is never acknowledged
  mcode_no_ack_a: assert property ($rose(highSpeedMode) |-> !sdaOe [*4])
    else $error("master code acknowledged");
  // leaving high speed follows a stop, bus idle
  hs_exit_idle_a: assert property ($fell(highSpeedMode) |-> sclIn && sdaIn)
    else $error("high speed left without stop");
endmodule : tws_slave_assertions

bind tws_slave_top tws_slave_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
  .core_clk(core_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .regPtr(regPtr), .regWrStrobe(regWrStrobe), .regWrData(regWrData),
  .highSpeedMode(highSpeedMode), .busTimeout(busTimeout)
);

//--- test/tb.sv
// self-checking bench of the two-wire slave
`timescale 1ns/1ps
module tb;
  localparam int TOC = 2000;    // shortened stall timeout, core cycles
  logic        core_clk = 1'b0;
  logic        linkClk  = 1'b0;
  logic        rst      = 1'b1;
  logic [1:0]  strH     = 2'h0; // high strap code
  logic [1:0]  strL     = 2'h0; // low strap code
  logic [15:0] rdData   = 16'h0000;
  logic        mScl, mSda, sclW, sdaW, sclOut, sclOe, sdaOut, sdaOe;
  logic [7:0]  regPtr;
  logic        regWrStrobe, highSpeedMode, busTimeout;
  logic [15:0] regWrData;
  logic [23:0] expQ[$];         // expected {pointer, word} per store
  int          errCount = 0;
  int          checked  = 0;
  always #5 core_clk = ~core_clk;
  // link clock, phase unrelated to the core clock
  initial begin
    #3;
    forever #16 linkClk = ~linkClk;
  end
  // open-drain lines: low if anyone pulls
  assign sclW = mScl & ~sclOe;
  assign sdaW = mSda & ~sdaOe;
  tws_slave_top #(.TIMEOUT_CYCLES(TOC)) dut (
    .core_clk(core_clk), .rst(rst), .linkClk(linkClk), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapHigh(strH), .addrStrapLow(strL),
    .regPtr(regPtr), .regWrStrobe(regWrStrobe), .regWrData(regWrData), .regRdData(rdData),
    .highSpeedMode(highSpeedMode), .busTimeout(busTimeout)
  );
  tws_bus_master bm (.scl(mScl), .sda(mSda), .sdaW(sdaW));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // master writes a byte, expecting ack or not
  task automatic sendb(input logic [7:0] d, input logic ack);
    logic [7:0] r;
    logic       a;
    bm.xfer(d, 1'b1, r, a);
    check(24'(a), 24'(!ack));
  endtask : sendb
  // master reads a byte and answers ack or nack
  task automatic rdb(input logic nack, input logic [7:0] e);
    logic [7:0] r;
    logic       a;
    bm.xfer(8'hFF, nack, r, a);
    check(24'(r), 24'(e));
  endtask : rdb
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // each store strobe takes the oldest expectation
  always @(negedge core_clk) begin
    if (regWrStrobe === 1'b1) begin
      if (expQ.size() == 0) check(24'h00_0000, 24'h00_0001);
      else check({regPtr, regWrData}, expQ.pop_front());
    end
  end
  // watchdog well past the planned run
  initial begin
    #1000us;
    errCount++;
    give_verdict();
  end
  initial begin
    logic [7:0]  p;
    logic [15:0] w;
    logic [3:0]  s;
    int          n;
    void'($urandom(8444));
    // reset spans enough link edges too
    repeat (13) @(negedge core_clk);
    rst = 1'b0;
    rdData = 16'hFFFF;
    repeat (30) @(negedge core_clk);
    // all sixteen strap codes, resampled at each start
    for (int i = 0; i < 16; i++) begin
      s = 4'(i);
      @(negedge core_clk) {strH, strL} = s;
      bm.start();
      sendb({3'h4, s, 1'b1}, 1'b1);
      bm.stop();
    end
    // strap mismatch refused
    bm.start();
    sendb(8'h8C, 1'b0);
    bm.stop();
    // word write with a dropped extra byte
    s = 4'($urandom);
    p = 8'($urandom);
    w = 16'($urandom);
    @(negedge core_clk) {strH, strL} = s;
    bm.start();
    sendb({3'h4, s, 1'b0}, 1'b1);
    sendb(p, 1'b1);
    expQ.push_back({p, w});
    sendb(w[15:8], 1'b1);
    sendb(w[7:0], 1'b1);
    sendb(8'($urandom), 1'b1);
    bm.stop();
    // read, nack, repeated start, read again
    w = 16'($urandom);
    @(negedge core_clk) rdData = w;
    bm.start();
    sendb({3'h4, s, 1'b1}, 1'b1);
    rdb(1'b0, w[15:8]);
    rdb(1'b1, w[7:0]);
    bm.start();
    sendb({3'h4, s, 1'b1}, 1'b1);
    rdb(1'b1, w[15:8]);
    bm.stop();
    check(24'(sdaOe), 24'h00_0000);
    check(24'(regPtr), 24'(p));
    // master code, then pointer-only write at high speed
    bm.start();
    sendb({5'h01, 3'($urandom)}, 1'b0);
    repeat (20) @(negedge core_clk);
    check(24'(highSpeedMode), 24'h00_0001);
    bm.qt = 300;
    p = 8'($urandom);
    bm.start();
    sendb({3'h4, s, 1'b0}, 1'b1);
    sendb(p, 1'b1);
    bm.start();
    sendb({3'h4, s, 1'b1}, 1'b1);
    rdb(1'b1, w[15:8]);
    check(24'(regPtr), 24'(p));
    bm.stop();
    bm.qt = 625;
    repeat (20) @(negedge core_clk);
    check(24'(highSpeedMode), 24'h00_0000);
    // stall with clock low while the device drives a zero
    @(negedge core_clk) rdData = 16'h0000;
    bm.start();
    sendb({3'h4, s, 1'b1}, 1'b1);
    n = 0;
    while (busTimeout !== 1'b1 && n < TOC + 200) begin
      @(negedge core_clk);
      n++;
    end
    check(24'(busTimeout), 24'h00_0001);
    repeat (40) @(negedge core_clk);
    check(24'(sdaOe), 24'h00_0000);
    bm.stop();
    check(24'(expQ.size()), 24'h00_0000);
    give_verdict();
  end
endmodule : tb
